// *** include/hub_port_map.vh ***
// Constants for the hub downstream port control block.
`ifndef HUB_PORT_MAP_VH
`define HUB_PORT_MAP_VH
`define NUM_PORTS 4
`define CLK_PERIOD_NS 100
`define FRAME_TIME_NS 1000000
`define FRAME_CYCLES (`FRAME_TIME_NS / `CLK_PERIOD_NS)
`define EOF1_TIME_NS 990000
`define EOF1_CYCLES (`EOF1_TIME_NS / `CLK_PERIOD_NS)
`define EOF2_TIME_NS 995000
`define EOF2_CYCLES (`EOF2_TIME_NS / `CLK_PERIOD_NS)
`define BLINK_FRAMES 8'h32
`define CNT_ZERO 14'h0000
`define CNT_ONE 14'h0001
`define FRAME_END 14'h270F
`define EOF1_AT 14'h26AC
`define EOF2_AT 14'h26DE
`define PORT_ZERO 4'h0
`define MODE_OC_BIT 1
`define ST_IDLE 2'h0
`define ST_DOWN 2'h1
`define ST_UP 2'h2
`define ST_BABBLE 2'h3
`endif

// *** verilog/hub_port_control.v ***
// Downstream port repeater, frame timers, port status, attach and indicator logic.
`timescale 1ns/100ps
`include "hub_port_map.vh"
// Summary of operation
// - Four downstream ports switched per packet.
// - Repeat packets between up and down; resume from up to down only.
// - Low-speed ports get downstream packets only after preamble.
// - EOF2 point catches silence and babble; EOF1 point blocks late upstream-bound packets.
// - Keep-alive strobe issued at each frame start.
// - Microcontroller reads port status and applies settings.
// - A connect or enable change on any port raises an interrupt.
// - Interrupt register names the port that changed.
// - Change bits also feed hub status endpoint.
// - Interrupt output alerts the microcontroller.
// - Links carry full and low speed rates.
// - Logic clock comes from fourfold multiplier.
// - Receive sampling at four times bit rate.
// - Upstream pull-up disconnected after reset.
// - Downstream pull-downs disconnected after reset.
// - Pull-up may be dropped and reconnected by command.
// - Pull-up connects only with bus power sensed.
// - Indicator on once enabled and traffic seen.
// - Indicator blinks on each valid upstream packet.
// - Valid packet needs good start and end.
// - All indicators off during global suspend.
// - Straps pick indicator or overcurrent pin mode.
// - Any port overcurrent disables all ports.
module hub_port_control (
  input wire CORE_CLK,
  input wire RST_B,
  // Per port enable commands; a clear in the same cycle beats a set.
  input wire [3:0] PORT_ENABLE_SET,
  input wire [3:0] PORT_ENABLE_CLR,
  input wire [3:0] PORT_LOW_SPEED,
  input wire [3:0] PORT_CONNECTED,
  input wire [3:0] CHANGE_READ,
  // Attach commands and the shared bus power sense, low when power is present.
  input wire PULLUP_CMD,
  input wire PULLDOWN_CMD,
  input wire SUPPLY_SENSE_IN_N,
  // Per port overcurrent inputs and the mode straps, read once after reset.
  input wire [3:0] PORT_OC_IN_N,
  input wire MODE_STRAP_LO,
  input wire MODE_STRAP_HI,
  // Suspend level and the packet framing events from both receiver sides.
  input wire GLOBAL_SUSPEND,
  input wire UP_PKT_START,
  input wire UP_PKT_PREAMBLE,
  input wire UP_PKT_END,
  input wire UP_RESUME,
  input wire [3:0] DN_PKT_START,
  input wire [3:0] DN_PKT_GOOD_END,
  input wire [3:0] DN_PKT_BAD_END,
  // Word stream through the two entry buffer, with valid and ready on each side.
  input wire UP_WORD_VALID,
  input wire [7:0] UP_WORD,
  output wire UP_WORD_READY,
  output wire DN_WORD_VALID,
  output reg [7:0] DN_WORD,
  input wire DN_WORD_READY,
  // Repeater routing, frame timing and error pulses.
  output reg [3:0] DN_FORWARD,
  output reg [3:0] DN_RESUME,
  output reg UP_FORWARD,
  output reg BABBLE_ERR,
  output reg ACTIVITY_LOST,
  output reg KEEP_ALIVE,
  output reg SAMPLE_EN,
  // Port state, latched changes and the interrupt toward the microcontroller.
  output reg [3:0] PORT_ENABLED,
  output reg [3:0] CHANGE_PENDING,
  output reg [3:0] OC_PORT,
  output reg INT_N,
  // Attach resistor switches and the active low indicator drives.
  output reg PULLUP_ON,
  output reg PULLDOWN_ON,
  output reg [3:0] PORT_INDICATOR_N
);

  // Frame timer counting core clock cycles within one frame.
  reg [13:0] frame_cnt_reg;
  // Sampling divider for the four times oversampling enable.
  reg [1:0] samp_cnt_reg;
  // Repeater state and the port currently repeating upstream.
  reg [1:0] state_reg;
  reg [1:0] up_port_reg;
  // Mode strap captured after reset release.
  reg mode_oc_reg;
  reg strap_done_reg;
  // Per port indicator state: traffic seen and blink frames left.
  reg [3:0] seen_reg;
  reg [7:0] blink_cnt_reg [0:3];
  // Previous enabled and connected state for change detection.
  reg [3:0] prev_conn_reg;
  reg [3:0] prev_en_reg;
  // Two entry buffer holding downstream-bound words.
  reg [7:0] buf_data_reg [0:1];
  reg [1:0] buf_cnt_reg;
  reg buf_rd_reg;
  reg buf_wr_reg;
  // Entry that will be at the head of the buffer after the coming edge.
  wire head_next;
  integer i;

  // Returns the lowest port number set in a four bit vector.
  // The lowest numbered port wins when several ports start in the same cycle.
  function [1:0] first_port;
    input [3:0] v;
    begin
      first_port = 2'h0;
      if (v[3]) begin
        first_port = 2'h3;
      end
      if (v[2]) begin
        first_port = 2'h2;
      end
      if (v[1]) begin
        first_port = 2'h1;
      end
      if (v[0]) begin
        first_port = 2'h0;
      end
    end
  endfunction

  // Buffer handshakes come straight from its fill count.
  assign UP_WORD_READY = (buf_cnt_reg != 2'h2);
  assign DN_WORD_VALID = (buf_cnt_reg != 2'h0);
  // The head moves on only when the receiver takes the current word.
  assign head_next = (DN_WORD_VALID && DN_WORD_READY) ? ~buf_rd_reg : buf_rd_reg;

  // Two entry buffer so that a stall downstream loses no word.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      // The buffer starts empty after reset.
      buf_cnt_reg <= 2'h0;
      buf_rd_reg <= 1'b0;
      buf_wr_reg <= 1'b0;
      buf_data_reg[0] <= 8'h00;
      buf_data_reg[1] <= 8'h00;
      DN_WORD <= 8'h00;
    end else begin
      // A write is accepted while an entry is free.
      if (UP_WORD_VALID && UP_WORD_READY) begin
        buf_data_reg[buf_wr_reg] <= UP_WORD;
        buf_wr_reg <= ~buf_wr_reg;
      end
      // A read advances only when the receiver takes the word.
      if (DN_WORD_VALID && DN_WORD_READY) begin
        buf_rd_reg <= ~buf_rd_reg;
      end
      buf_cnt_reg <= buf_cnt_reg + {1'b0, UP_WORD_VALID && UP_WORD_READY}
        - {1'b0, DN_WORD_VALID && DN_WORD_READY};
      // The data output is loaded with the entry that is the head after this edge.
      // A word written into that very entry now comes straight from the input, so
      // the output never shows a stale word in the first cycle that valid is high.
      if (UP_WORD_VALID && UP_WORD_READY && buf_wr_reg == head_next) begin
        DN_WORD <= UP_WORD;
      end else begin
        DN_WORD <= buf_data_reg[head_next];
      end
    end
  end

  // Frame timer, EOF points, keep-alive and sample enable.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      frame_cnt_reg <= `CNT_ZERO;
      // The sample divider restarts together with the frame timer.
      samp_cnt_reg <= 2'h0;
      KEEP_ALIVE <= 1'b0;
      SAMPLE_EN <= 1'b0;
    end else begin
      // The count wraps at the last core clock cycle of the frame.
      if (frame_cnt_reg == `FRAME_END) begin
        frame_cnt_reg <= `CNT_ZERO;
      end else begin
        frame_cnt_reg <= frame_cnt_reg + `CNT_ONE;
      end
      // Strobe issued in the cycle the new frame begins.
      KEEP_ALIVE <= (frame_cnt_reg == `FRAME_END);
      // One enable in four cycles drives the oversampling front end.
      samp_cnt_reg <= samp_cnt_reg + 2'h1;
      SAMPLE_EN <= (samp_cnt_reg == 2'h3);
    end
  end

  // Capture the mode straps once, one cycle after reset release.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      // Indicator mode holds until the straps have been read.
      mode_oc_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      // The high strap alone selects overcurrent mode.
      mode_oc_reg <= MODE_STRAP_HI;
      strap_done_reg <= 1'b1;
    end
  end

  // Packet repeater: routes downstream and upstream traffic by packet.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= `ST_IDLE;
      // Reset leaves every repeat path closed.
      up_port_reg <= 2'h0;
      DN_FORWARD <= `PORT_ZERO;
      DN_RESUME <= `PORT_ZERO;
      UP_FORWARD <= 1'b0;
      BABBLE_ERR <= 1'b0;
      ACTIVITY_LOST <= 1'b0;
    end else begin
      BABBLE_ERR <= 1'b0;
      ACTIVITY_LOST <= 1'b0;
      // Resume is repeated to every enabled port.
      DN_RESUME <= UP_RESUME ? PORT_ENABLED : `PORT_ZERO;
      case (state_reg)
        `ST_IDLE: begin
          // An upstream start has priority over a downstream start in the same cycle.
          if (UP_PKT_START && frame_cnt_reg < `EOF2_AT) begin
            // Low speed ports are only reached after a preamble.
            DN_FORWARD <= PORT_ENABLED & (UP_PKT_PREAMBLE ? 4'hF : ~PORT_LOW_SPEED);
            state_reg <= `ST_DOWN;
          end else if ((|(DN_PKT_START & PORT_ENABLED)) && frame_cnt_reg < `EOF1_AT) begin
            up_port_reg <= first_port(DN_PKT_START & PORT_ENABLED);
            UP_FORWARD <= 1'b1;
            state_reg <= `ST_UP;
          end
        end
        `ST_DOWN: begin
          // The end of the packet closes every downstream path.
          if (UP_PKT_END) begin
            DN_FORWARD <= `PORT_ZERO;
            state_reg <= `ST_IDLE;
          end else if (frame_cnt_reg == `EOF2_AT) begin
            // Upstream still busy at the second point: activity lost.
            ACTIVITY_LOST <= 1'b1;
            DN_FORWARD <= `PORT_ZERO;
            state_reg <= `ST_IDLE;
          end
        end
        `ST_UP: begin
          // The end of the packet, good or bad, closes the upstream path.
          if (DN_PKT_GOOD_END[up_port_reg] || DN_PKT_BAD_END[up_port_reg]) begin
            UP_FORWARD <= 1'b0;
            state_reg <= `ST_IDLE;
          end else if (frame_cnt_reg == `EOF2_AT) begin
            // A port still talking at the second point is babbling.
            BABBLE_ERR <= 1'b1;
            UP_FORWARD <= 1'b0;
            state_reg <= `ST_BABBLE;
          end
        end
        `ST_BABBLE: begin
          // Hold off until the next frame begins.
          if (frame_cnt_reg == `FRAME_END) begin
            state_reg <= `ST_IDLE;
          end
        end
        default: begin
          state_reg <= `ST_IDLE;
        end
      endcase
    end
  end

  // Port enables, overcurrent shutdown, change latching and interrupt.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_ENABLED <= `PORT_ZERO;
      CHANGE_PENDING <= `PORT_ZERO;
      // No port is enabled and nothing is pending after reset.
      OC_PORT <= `PORT_ZERO;
      prev_conn_reg <= `PORT_ZERO;
      prev_en_reg <= `PORT_ZERO;
      INT_N <= 1'b1;
    end else begin
      // The last levels are kept so that a toggle shows as a change.
      prev_conn_reg <= PORT_CONNECTED;
      prev_en_reg <= PORT_ENABLED;
      if (mode_oc_reg && (|(~PORT_OC_IN_N))) begin
        // One port in overcurrent shuts every port; the culprit stays marked.
        PORT_ENABLED <= `PORT_ZERO;
        OC_PORT <= OC_PORT | ~PORT_OC_IN_N;
      end else begin
        PORT_ENABLED <= (PORT_ENABLED | PORT_ENABLE_SET) & ~PORT_ENABLE_CLR;
        OC_PORT <= OC_PORT & ~CHANGE_READ;
      end
      // A new change wins over a read in the same cycle.
      CHANGE_PENDING <= (CHANGE_PENDING & ~CHANGE_READ)
        | (prev_conn_reg ^ PORT_CONNECTED) | (prev_en_reg ^ PORT_ENABLED);
      // Held low while any change is unread.
      INT_N <= ~(|((CHANGE_PENDING & ~CHANGE_READ)
        | (prev_conn_reg ^ PORT_CONNECTED) | (prev_en_reg ^ PORT_ENABLED)));
    end
  end

  // Attach resistors: off after reset, on by command, pull-up gated by bus power.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      // Both resistors stay switched off after reset.
      PULLUP_ON <= 1'b0;
      PULLDOWN_ON <= 1'b0;
    end else begin
      // Dropping the command detaches; raising it reattaches.
      PULLUP_ON <= PULLUP_CMD & ~SUPPLY_SENSE_IN_N;
      PULLDOWN_ON <= PULLDOWN_CMD;
    end
  end

  // Indicators: on after good traffic, blink off per packet, dark in suspend.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      // Every indicator is dark after reset.
      seen_reg <= `PORT_ZERO;
      PORT_INDICATOR_N <= 4'hF;
      for (i = 0; i < `NUM_PORTS; i = i + 1) begin
        blink_cnt_reg[i] <= 8'h00;
      end
    end else begin
      for (i = 0; i < `NUM_PORTS; i = i + 1) begin
        // A disabled port forgets its traffic and its blink.
        if (!PORT_ENABLED[i]) begin
          seen_reg[i] <= 1'b0;
          blink_cnt_reg[i] <= 8'h00;
        end else if (DN_PKT_GOOD_END[i] && state_reg == `ST_UP && up_port_reg == i) begin
          // Only a packet with good start and end counts.
          seen_reg[i] <= 1'b1;
          blink_cnt_reg[i] <= `BLINK_FRAMES;
        end else if (KEEP_ALIVE && blink_cnt_reg[i] != 8'h00) begin
          blink_cnt_reg[i] <= blink_cnt_reg[i] - 8'h01;
        end
        // In overcurrent mode the pins are inputs, so the drive stays off.
        if (mode_oc_reg || GLOBAL_SUSPEND) begin
          PORT_INDICATOR_N[i] <= 1'b1;
        end else begin
          PORT_INDICATOR_N[i] <= ~(seen_reg[i] && blink_cnt_reg[i] == 8'h00);
        end
      end
    end
  end

endmodule

// *** verif/hub_port_control_props.sv ***
// Concurrent checks on the ports of the hub port control block.
`timescale 1ns/100ps
module hub_port_control_props (
  input wire CORE_CLK, RST_B, PULLUP_CMD, SUPPLY_SENSE_IN_N, MODE_STRAP_HI, GLOBAL_SUSPEND,
  input wire UP_PKT_START, UP_PKT_PREAMBLE, UP_RESUME, UP_FORWARD, BABBLE_ERR, ACTIVITY_LOST,
  input wire KEEP_ALIVE, SAMPLE_EN, INT_N, PULLUP_ON,
  input wire [3:0] PORT_LOW_SPEED, PORT_OC_IN_N, DN_FORWARD, DN_RESUME, PORT_ENABLED,
  input wire [3:0] CHANGE_PENDING, PORT_INDICATOR_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Cycles since the last keep-alive strobe, so the frame period can be measured.
  reg [13:0] gap_reg;
  // Set once a first strobe has been seen, as the first gap is unknown.
  reg seen_reg;
  // The counter restarts on every strobe.
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_reg <= 14'h0000;
      seen_reg <= 1'h0;
    end else begin
      gap_reg <= KEEP_ALIVE ? 14'h0000 : gap_reg + 14'h0001;
      seen_reg <= seen_reg | KEEP_ALIVE;
    end
  end
  a_pullup_needs_power: assert property (PULLUP_ON |-> $past(PULLUP_CMD) && !$past(SUPPLY_SENSE_IN_N))
    else $error("pull-up connected without command or bus power");
  a_down_fanout: assert property (UP_PKT_START && !(|DN_FORWARD) && !UP_FORWARD |=>
    DN_FORWARD == ($past(PORT_ENABLED) & ~($past(UP_PKT_PREAMBLE) ? 4'h0 : $past(PORT_LOW_SPEED))))
    else $error("downstream fan-out wrong");
  a_resume_fanout: assert property (UP_RESUME |=> DN_RESUME == $past(PORT_ENABLED))
    else $error("resume not repeated to enabled ports");
  a_frame_strobe: assert property (KEEP_ALIVE && seen_reg |-> gap_reg == 14'h270F)
    else $error("keep-alive period wrong");
  a_sample_rate: assert property (SAMPLE_EN |=> !SAMPLE_EN [*3] ##1 SAMPLE_EN)
    else $error("sample enable not every fourth cycle");
  a_silence_cut: assert property (ACTIVITY_LOST |-> ##[0:1] DN_FORWARD == 4'h0)
    else $error("downstream repeat not cut on lost activity");
  a_babble_cut: assert property (BABBLE_ERR |-> ##[0:1] !UP_FORWARD)
    else $error("upstream repeat not cut on babble");
  a_int_pending: assert property ((|CHANGE_PENDING) |-> !INT_N)
    else $error("interrupt not asserted with a pending change");
  a_suspend_dark: assert property (GLOBAL_SUSPEND ##1 GLOBAL_SUSPEND |-> PORT_INDICATOR_N == 4'hF)
    else $error("indicator lit in suspend");
  a_oc_all_off: assert property ((MODE_STRAP_HI && !(&PORT_OC_IN_N)) [*2] |=> PORT_ENABLED == 4'h0)
    else $error("ports left enabled on overcurrent");
  c_keep_alive: cover property (KEEP_ALIVE);
  c_babble: cover property (BABBLE_ERR);
  c_lost: cover property (ACTIVITY_LOST);
  c_suspend: cover property (GLOBAL_SUSPEND ##1 GLOBAL_SUSPEND);
endmodule
bind hub_port_control hub_port_control_props props_u (.*);

// *** verif/hub_word_sink.sv ***
// Far-side receiver of the repeated word stream, able to stall.
`timescale 1ns/100ps
module hub_word_sink (
  input wire clk,
  input wire valid,
  input wire [7:0] word,
  input wire stall,
  output reg ready,
  output reg [7:0] last_word,
  output reg [7:0] word_count
);
  // Ready follows the stall request by non-blocking assignment at the rising edge,
  // so the block always samples the value that stood before that edge.
  always @(posedge clk) ready <= !stall;
  // A word is taken where valid and ready meet; a duplicate would show in the count.
  always @(posedge clk) begin
    if (valid && ready) begin
      last_word <= word;
      word_count <= word_count + 8'h01;
    end
  end
  initial begin
    ready = 1'h0;
    last_word = 8'h00;
    word_count = 8'h00;
  end
endmodule

// *** verif/hub_port_control_tb.sv ***
// Self-checking bench for the hub port control block.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module hub_port_control_tb;
  reg CORE_CLK = 1'h0, RST_B = 1'h0, PULLUP_CMD = 1'h0, PULLDOWN_CMD = 1'h0;
  reg SUPPLY_SENSE_IN_N = 1'h1, MODE_STRAP_LO = 1'h0, MODE_STRAP_HI = 1'h0, GLOBAL_SUSPEND = 1'h0;
  reg UP_PKT_START = 1'h0, UP_PKT_PREAMBLE = 1'h0, UP_PKT_END = 1'h0, UP_RESUME = 1'h0;
  reg UP_WORD_VALID = 1'h0, stall = 1'h1;
  reg [3:0] PORT_ENABLE_SET = 4'h0, PORT_ENABLE_CLR = 4'h0, PORT_LOW_SPEED = 4'h0;
  reg [3:0] PORT_CONNECTED = 4'h0, CHANGE_READ = 4'h0, PORT_OC_IN_N = 4'hF, DN_PKT_START = 4'h0;
  reg [3:0] DN_PKT_GOOD_END = 4'h0, DN_PKT_BAD_END = 4'h0;
  reg [7:0] UP_WORD = 8'h00;
  wire UP_WORD_READY, DN_WORD_VALID, DN_WORD_READY, UP_FORWARD, BABBLE_ERR, ACTIVITY_LOST;
  wire KEEP_ALIVE, SAMPLE_EN, INT_N, PULLUP_ON, PULLDOWN_ON;
  wire [7:0] DN_WORD, last_word, word_count;
  wire [3:0] DN_FORWARD, DN_RESUME, PORT_ENABLED, CHANGE_PENDING, OC_PORT, PORT_INDICATOR_N;
  integer compares = 0, miscompares = 0, cycles = 0, i;
  // Attach rows: command, sense, pull-down command, then expected pull-up and pull-down.
  reg [4:0] rows [0:4] = '{5'h17, 5'h00, 5'h12, 5'h18, 5'h05};
  hub_port_control dut_u (.*);
  hub_word_sink sink_u (.clk(CORE_CLK), .valid(DN_WORD_VALID), .word(DN_WORD), .stall(stall),
    .ready(DN_WORD_READY), .last_word(last_word), .word_count(word_count));
  // Clock of 100 ns period.
  always #50 CORE_CLK = ~CORE_CLK;
  // A hang is cut off well past the three frames the run needs.
  always @(posedge CORE_CLK) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      final_report;
    end
  end
  // Prints the counts and the verdict, then stops.
  task final_report;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Lets a number of falling edges pass.
  task tick(input integer n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  // Waits, bounded, for keep-alive (0), lost activity (1) or babble (2).
  task wait_ev(input integer w);
    integer n;
    begin
      n = 0;
      while (!(w == 0 ? KEEP_ALIVE : w == 1 ? ACTIVITY_LOST : BABBLE_ERR) && n < 10100) begin
        @(negedge CORE_CLK);
        n = n + 1;
      end
      `CHK("frame event", 1'h1, n < 10100)
    end
  endtask
  // Offers a word and holds it until the edge at which ready is high.
  task push(input [7:0] w);
    integer n;
    begin
      UP_WORD_VALID = 1'h1;
      UP_WORD = w;
      for (n = 0; !UP_WORD_READY && n < 50; n++) @(negedge CORE_CLK);
      @(negedge CORE_CLK);
    end
  endtask
  // Sends one downstream packet start and checks the fan-out, then ends it.
  task pkt(input pre, input [3:0] ex);
    begin
      UP_PKT_START = 1'h1;
      UP_PKT_PREAMBLE = pre;
      tick(1);
      UP_PKT_START = 1'h0;
      tick(1);
      `CHK("fan-out", ex, DN_FORWARD)
      UP_PKT_END = 1'h1;
      tick(1);
      UP_PKT_END = 1'h0;
      tick(2);
      `CHK("fan-out end", 4'h0, DN_FORWARD)
    end
  endtask
  initial begin
    tick(6);
    RST_B = 1'h1;
    tick(2);
    `CHK("irq", 1'h1, INT_N)
    `CHK("pull-up", 1'h0, PULLUP_ON)
    `CHK("pull-down", 1'h0, PULLDOWN_ON)
    for (i = 0; i < 5; i++) begin
      {PULLUP_CMD, SUPPLY_SENSE_IN_N, PULLDOWN_CMD} = rows[i][4:2];
      tick(3);
      `CHK("pull-up", rows[i][1], PULLUP_ON)
      `CHK("pull-down", rows[i][0], PULLDOWN_ON)
    end
    // Enable with a clear overlapping port 3; the clear wins.
    PORT_ENABLE_SET = 4'hF;
    PORT_ENABLE_CLR = 4'h8;
    tick(1);
    PORT_ENABLE_SET = 4'h0;
    PORT_ENABLE_CLR = 4'h0;
    tick(3);
    `CHK("enabled", 4'h7, PORT_ENABLED)
    `CHK("pending", 4'h7, CHANGE_PENDING)
    CHANGE_READ = 4'h7;
    PORT_CONNECTED = 4'h8;
    PORT_ENABLE_SET = 4'h8;
    tick(1);
    CHANGE_READ = 4'h0;
    PORT_ENABLE_SET = 4'h0;
    tick(3);
    `CHK("pending", 4'h8, CHANGE_PENDING)
    `CHK("irq", 1'h0, INT_N)
    CHANGE_READ = 4'h8;
    tick(1);
    CHANGE_READ = 4'h0;
    tick(2);
    `CHK("irq", 1'h1, INT_N)
    PORT_LOW_SPEED = 4'h4;
    pkt(1'h0, 4'hB);
    pkt(1'h1, 4'hF);
    UP_RESUME = 1'h1;
    tick(3);
    `CHK("resume", 4'hF, DN_RESUME)
    UP_RESUME = 1'h0;
    DN_PKT_START = 4'h2;
    tick(1);
    DN_PKT_START = 4'h0;
    tick(1);
    `CHK("upstream", 1'h1, UP_FORWARD)
    DN_PKT_GOOD_END = 4'h2;
    tick(1);
    DN_PKT_GOOD_END = 4'h0;
    tick(2);
    `CHK("upstream end", 1'h0, UP_FORWARD)
    `CHK("blink off", 4'hF, PORT_INDICATOR_N)
    // Global suspend keeps every indicator dark.
    GLOBAL_SUSPEND = 1'h1;
    tick(2);
    `CHK("suspend dark", 4'hF, PORT_INDICATOR_N)
    GLOBAL_SUSPEND = 1'h0;
    // Fill the buffer against a stalled receiver, then drain it.
    push(8'hA5);
    `CHK("first valid", 1'h1, DN_WORD_VALID)
    `CHK("first word", 8'hA5, DN_WORD)
    push(8'h3C);
    `CHK("refused", 1'h0, UP_WORD_READY)
    `CHK("head word", 8'hA5, DN_WORD)
    UP_WORD = 8'h5A;
    stall = 1'h0;
    push(8'h5A);
    UP_WORD_VALID = 1'h0;
    tick(6);
    `CHK("word count", 8'h03, word_count)
    `CHK("last word", 8'h5A, last_word)
    `CHK("drained", 1'h0, DN_WORD_VALID)
    // A packet left open must be cut at the EOF2 point, before the frame ends.
    wait_ev(0);
    pkt(1'h1, 4'hF);
    UP_PKT_START = 1'h1;
    tick(1);
    UP_PKT_START = 1'h0;
    wait_ev(1);
    wait_ev(0);
    DN_PKT_START = 4'h1;
    tick(1);
    DN_PKT_START = 4'h0;
    wait_ev(2);
    // Second reset in overcurrent mode.
    RST_B = 1'h0;
    MODE_STRAP_HI = 1'h1;
    tick(2);
    RST_B = 1'h1;
    tick(2);
    PORT_ENABLE_SET = 4'hF;
    tick(1);
    PORT_ENABLE_SET = 4'h0;
    tick(2);
    `CHK("enabled", 4'hF, PORT_ENABLED)
    PORT_OC_IN_N = 4'hB;
    tick(3);
    `CHK("enabled", 4'h0, PORT_ENABLED)
    `CHK("oc port", 4'h4, OC_PORT)
    PORT_OC_IN_N = 4'hF;
    CHANGE_READ = 4'hF;
    tick(1);
    CHANGE_READ = 4'h0;
    tick(2);
    `CHK("oc port", 4'h0, OC_PORT)
    final_report;
  end
endmodule
